// [dcrc_cpu_end.sv]
// processor core and code flash end: halt control, crc writes and flash read port
module dcrc_cpu_end
    import dcrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    dcrc_if.cpu_end bus,
    input wire logic user_ctl_wr,
    input wire logic [7:0] user_ctl_data,
    input wire logic user_halt,
    input wire logic user_fast_seed_wr,
    input wire logic user_gp_seed_wr,
    input wire logic [15:0] user_seed_data,
    input wire logic user_gp_wr,
    input wire logic [7:0] user_gp_byte,
    output logic [DCRC_BADDR_W-1:0] user_flash_addr,
    input wire logic [31:0] user_flash_word,
    output logic user_halted,
    output logic user_done,
    output logic [15:0] user_fast_result,
    output logic [15:0] user_gp_result
);
    logic halted_r;
    logic ctl_wr_r;
    logic [7:0] ctl_data_r;
    logic fast_seed_wr_r;
    logic gp_seed_wr_r;
    logic [15:0] seed_data_r;
    logic gp_wr_r;
    logic [7:0] gp_byte_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic done_r;
    logic [15:0] fast_res_r;
    logic [15:0] gp_res_r;

    // halt refused while a control write is in flight; wake from the crc end resumes the core
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            halted_r <= 1'b0;
        end else if (bus.wake) begin
            halted_r <= 1'b0;
        end else if (user_halt && !ctl_wr_r && !user_ctl_wr) begin
            halted_r <= 1'b1;
        end
    end

    // writes are stopped while halted, as no code runs then
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_wr_r <= 1'b0;
            ctl_data_r <= DCRC_CTL_RST;
            fast_seed_wr_r <= 1'b0;
            gp_seed_wr_r <= 1'b0;
            seed_data_r <= DCRC_ACC_RST;
            gp_wr_r <= 1'b0;
            gp_byte_r <= 8'h00;
        end else begin
            ctl_wr_r <= user_ctl_wr && !halted_r;
            ctl_data_r <= user_ctl_data;
            fast_seed_wr_r <= user_fast_seed_wr && !halted_r;
            gp_seed_wr_r <= user_gp_seed_wr && !halted_r;
            seed_data_r <= user_seed_data;
            gp_wr_r <= user_gp_wr && !halted_r;
            gp_byte_r <= user_gp_byte;
        end
    end

    // code flash answers each read one clock later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rvalid_r <= 1'b0;
            rdata_r <= DCRC_WORD_RST;
        end else begin
            rvalid_r <= bus.flash_rd;
            rdata_r <= user_flash_word;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_r <= 1'b0;
            fast_res_r <= DCRC_ACC_RST;
            gp_res_r <= DCRC_ACC_RST;
        end else begin
            done_r <= bus.wake;
            fast_res_r <= bus.fast_result;
            gp_res_r <= bus.gp_result;
        end
    end

    assign bus.cpu_halted = halted_r;
    assign bus.ctl_wr = ctl_wr_r;
    assign bus.ctl_data = ctl_data_r;
    assign bus.fast_seed_wr = fast_seed_wr_r;
    assign bus.gp_seed_wr = gp_seed_wr_r;
    assign bus.seed_data = seed_data_r;
    assign bus.gp_wr = gp_wr_r;
    assign bus.gp_byte = gp_byte_r;
    assign bus.flash_rvalid = rvalid_r;
    assign bus.flash_rdata = rdata_r;
    assign user_flash_addr = bus.flash_addr;
    assign user_halted = halted_r;
    assign user_done = done_r;
    assign user_fast_result = fast_res_r;
    assign user_gp_result = gp_res_r;
endmodule : dcrc_cpu_end

// [dcrc_crc_end.sv]
// crc unit end: word buffer, fast flash sweep engine and byte engine
// Function
// - fast engine reads code flash only
// - sweep runs only while cpu halted
// - one 32-bit word absorbed per clock
// - poly 0x11021, bit 31 first, unreflected
// - fast result not bit-reflected
// - highest-addressed byte is msb, shifted first
// - result low byte low, high byte next
// - software keeps reference crc in last word
// - byte engine takes bytes from anywhere
// - byte engine absorbs byte within two cycles
// - updated crc readable after every byte
// - byte engine poly 0x11021, bit 0 first
// - byte engine result is bit-reflected
// - software reorders bytes to emulate fast engine
// - sweep is whole 16K blocks minus four bytes
// - start zero, end by six-bit field, others prohibited
// - software disables interrupts, sets control, halts

module dcrc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32,
    parameter int CNT_W = 6
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [CNT_W-1:0] count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CNT_W-1:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != CNT_W'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr_r];
    assign count = cnt_r;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (push && !pop) begin
            cnt_r <= cnt_r + CNT_W'(1);
        end else if (pop && !push) begin
            cnt_r <= cnt_r - CNT_W'(1);
        end
    end
endmodule : dcrc_fifo

module dcrc_crc_end
    import dcrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    dcrc_if.crc_end bus,
    output logic ctl_enable,
    output logic [5:0] ctl_end_block,
    output logic range_err
);
    dcrc_state_t state_r;
    dcrc_state_t state_nxt;
    logic [7:0] ctl_r;
    logic [15:0] fast_acc_r;
    logic [15:0] gp_acc_r;
    logic [17:0] issued_r;
    logic [17:0] absorbed_r;
    logic inflight_r;
    logic wake_r;
    logic range_err_r;
    logic [17:0] words_total;
    logic blk_ok;
    logic issue;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic [DCRC_FIFO_CNT_W-1:0] fifo_count;
    logic absorb;
    logic last_absorb;
    logic start;

    logic [5:0] blk;
    assign blk = ctl_r[DCRC_CTL_BLK_LSB +: DCRC_CTL_BLK_W];
    assign blk_ok = (blk <= DCRC_BLK_MAX);
    // (field + 1) blocks of 4096 words, less the final word that holds the reference
    assign words_total = 18'((18'(blk) + 18'h0_0001) << DCRC_BLK_SHIFT) - 18'h0_0001;
    assign start = (state_r == DCRC_S_IDLE) && ctl_r[DCRC_CTL_EN_BIT] && bus.cpu_halted;

    // reserve a slot for the read still in flight so the buffer never overruns
    assign issue = (state_r == DCRC_S_SWEEP) && (issued_r < words_total) && fifo_in_ready
        && ((32'(fifo_count) + 32'(inflight_r) + 32'd1) <= DCRC_FIFO_DEPTH);
    // drain stalls if the core leaves halt, so no word is absorbed while code runs
    assign fifo_out_ready = (state_r == DCRC_S_SWEEP) && bus.cpu_halted;
    assign absorb = fifo_out_valid && fifo_out_ready;
    assign last_absorb = absorb && (absorbed_r == words_total - 18'h0_0001);

    dcrc_fifo #(
        .WIDTH(DCRC_FIFO_W),
        .DEPTH(DCRC_FIFO_DEPTH),
        .CNT_W(DCRC_FIFO_CNT_W)
    ) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(bus.flash_rvalid),
        .in_ready(fifo_in_ready),
        .in_data(bus.flash_rdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DCRC_S_IDLE: begin
                if (start) begin
                    state_nxt = blk_ok ? DCRC_S_SWEEP : DCRC_S_DONE;
                end
            end
            DCRC_S_SWEEP: begin
                if (last_absorb) begin
                    state_nxt = DCRC_S_DONE;
                end
            end
            DCRC_S_DONE: begin
                state_nxt = DCRC_S_IDLE;
            end
            default: begin
                state_nxt = DCRC_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= DCRC_S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // control: ignored while a sweep runs, enable drops once the sweep ends
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_r <= DCRC_CTL_RST;
        end else if (state_r == DCRC_S_DONE) begin
            ctl_r[DCRC_CTL_EN_BIT] <= 1'b0;
        end else if (bus.ctl_wr && state_r == DCRC_S_IDLE) begin
            ctl_r <= bus.ctl_data & 8'hBF;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            range_err_r <= 1'b0;
        end else if (start) begin
            range_err_r <= !blk_ok;
        end
    end

    // flash reads walk word addresses upward from zero, inside code flash only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            issued_r <= DCRC_CNT_RST;
            absorbed_r <= DCRC_CNT_RST;
            inflight_r <= 1'b0;
        end else begin
            inflight_r <= issue;
            if (start) begin
                issued_r <= 18'(DCRC_SWEEP_START);
                absorbed_r <= DCRC_CNT_RST;
            end else begin
                if (issue) begin
                    issued_r <= issued_r + 18'h0_0001;
                end
                if (absorb) begin
                    absorbed_r <= absorbed_r + 18'h0_0001;
                end
            end
        end
    end

    // flash word is little-endian, so bit 31 is the msb of the highest-addressed byte
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_acc_r <= DCRC_ACC_RST;
        end else if (absorb) begin
            fast_acc_r <= dcrc_step_word(fast_acc_r, fifo_out_data);
        end else if (bus.fast_seed_wr && state_r == DCRC_S_IDLE) begin
            fast_acc_r <= bus.seed_data;
        end
    end

    // one byte per clock, result ready on the next edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gp_acc_r <= DCRC_ACC_RST;
        end else if (bus.gp_wr) begin
            gp_acc_r <= dcrc_step_byte(gp_acc_r, bus.gp_byte);
        end else if (bus.gp_seed_wr) begin
            gp_acc_r <= bus.seed_data;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= (state_nxt == DCRC_S_DONE) && (state_r != DCRC_S_DONE);
        end
    end

    assign bus.flash_rd = issue;
    assign bus.flash_addr = {issued_r[DCRC_WADDR_W-1:0], 2'b00};
    assign bus.wake = wake_r;
    assign bus.sweep_busy = (state_r == DCRC_S_SWEEP);
    assign bus.fast_result = fast_acc_r;
    assign bus.gp_result = gp_acc_r;
    assign ctl_enable = ctl_r[DCRC_CTL_EN_BIT];
    assign ctl_end_block = blk;
    assign range_err = range_err_r;
endmodule : dcrc_crc_end

// [dcrc_dual_crc16_checker_tb.sv]
// self-checking bench for both ends of the dual crc unit and its word buffer
module dcrc_dual_crc16_checker_tb
    import dcrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, rst_b, user_ctl_wr, user_halt, user_fast_seed_wr, user_gp_seed_wr, user_gp_wr;
    logic [7:0] user_ctl_data, user_gp_byte;
    logic [15:0] user_seed_data, user_fast_result, user_gp_result, exp_crc, got;
    logic [DCRC_BADDR_W-1:0] user_flash_addr;
    logic [31:0] user_flash_word, w;
    logic user_halted, user_done, ctl_enable, range_err;
    logic [5:0] ctl_end_block;
    int bad_count, comparisons, n_rd, n_rv, n_busy;

    // arbitrary image, byte lanes 0 and 2 change from word to word, lanes 1 and 3 every 256 words
    function automatic logic [31:0] flash_word(input logic [DCRC_BADDR_W-1:0] a);
        return {a[17:2] ^ 16'hC3A5, ~a[17:2]};
    endfunction : flash_word

    assign user_flash_word = flash_word(user_flash_addr);

    function automatic logic [15:0] msb_bit(input logic [15:0] r, input logic d);
        return {r[14:0], 1'b0} ^ ((r[15] ^ d) ? 16'h1021 : 16'h0000);
    endfunction : msb_bit

    function automatic logic [15:0] ref_word(input logic [15:0] c, input logic [31:0] w);
        for (int i = 31; i >= 0; i--) c = msb_bit(c, w[i]);
        return c;
    endfunction : ref_word

    // reflected engine modelled as a plain one on reversed state, not as a shift-right
    function automatic logic [15:0] ref_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = {<<{c}};
        for (int i = 0; i < 8; i++) r = msb_bit(r, b[i]);
        return {<<{r}};
    endfunction : ref_byte

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, want);
        end
    endtask : check

    task automatic stop_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // one request pulse: 0 byte, 1 byte seed, 2 fast seed, 3 control, 4 halt
    task automatic user_req(input int kind, input logic [15:0] val);
        @(posedge clk);
        user_gp_byte <= val[7:0];
        user_ctl_data <= val[7:0];
        user_seed_data <= val;
        {user_gp_wr, user_gp_seed_wr, user_fast_seed_wr, user_ctl_wr, user_halt} <= 5'h10 >> kind;
        @(posedge clk);
        {user_gp_wr, user_gp_seed_wr, user_fast_seed_wr, user_ctl_wr, user_halt} <= 5'h00;
    endtask : user_req

    task automatic wait_done(input int limit);
        int n;
        n = 0;
        n_rd = 0;
        n_rv = 0;
        n_busy = 0;
        while (user_done !== 1'b1 && n < limit) begin
            @(posedge clk);
            n++;
            // read before this edge's updates land, so each cycle counts once
            n_rd += int'(dcrc_if_i.flash_rd === 1'b1);
            n_rv += int'(dcrc_if_i.flash_rvalid === 1'b1);
            n_busy += int'(dcrc_if_i.sweep_busy === 1'b1);
        end
        if (n >= limit) begin
            bad_count++;
            $display("wrong value at %0t ns: sweep never finished", $time);
            stop_test();
        end
    endtask : wait_done

    dcrc_if dcrc_if_i ();

    dcrc_crc_end dcrc_crc_end_i (.clk(clk), .rst_b(rst_b), .bus(dcrc_if_i.crc_end), .ctl_enable(ctl_enable),
        .ctl_end_block(ctl_end_block), .range_err(range_err));

    dcrc_cpu_end dcrc_cpu_end_i (.clk(clk), .rst_b(rst_b), .bus(dcrc_if_i.cpu_end), .user_ctl_wr(user_ctl_wr),
        .user_ctl_data(user_ctl_data), .user_halt(user_halt), .user_fast_seed_wr(user_fast_seed_wr),
        .user_gp_seed_wr(user_gp_seed_wr), .user_seed_data(user_seed_data), .user_gp_wr(user_gp_wr),
        .user_gp_byte(user_gp_byte), .user_flash_addr(user_flash_addr), .user_flash_word(user_flash_word),
        .user_halted(user_halted), .user_done(user_done), .user_fast_result(user_fast_result),
        .user_gp_result(user_gp_result));

    dcrc_link_chk dcrc_link_chk_i (.clk(clk), .rst_b(rst_b), .cpu_halted(dcrc_if_i.cpu_halted),
        .ctl_wr(dcrc_if_i.ctl_wr), .ctl_data(dcrc_if_i.ctl_data), .fast_seed_wr(dcrc_if_i.fast_seed_wr),
        .gp_seed_wr(dcrc_if_i.gp_seed_wr), .seed_data(dcrc_if_i.seed_data), .gp_wr(dcrc_if_i.gp_wr),
        .wake(dcrc_if_i.wake), .sweep_busy(dcrc_if_i.sweep_busy), .fast_result(dcrc_if_i.fast_result),
        .gp_result(dcrc_if_i.gp_result), .flash_rd(dcrc_if_i.flash_rd), .flash_addr(dcrc_if_i.flash_addr),
        .flash_rvalid(dcrc_if_i.flash_rvalid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        int k;
        logic [7:0] b;
        rst_b = 1'b0;
        {user_gp_wr, user_gp_seed_wr, user_fast_seed_wr, user_ctl_wr, user_halt} = 5'h00;
        {user_ctl_data, user_gp_byte, user_seed_data} = 32'h0000_0000;
        bad_count = 0;
        comparisons = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        settle(1);
        check(32'(user_fast_result), 32'h0000_0000);
        exp_crc = 16'h0000;
        check(32'(user_gp_result), 32'(exp_crc));
        for (int i = 0; i < 4; i++) begin
            b = 8'hA1 ^ 8'(i * 29);
            user_req(0, {8'h00, b});
            exp_crc = ref_byte(exp_crc, b);
            settle(3);
            check(32'(user_gp_result), 32'(exp_crc));
        end
        user_req(1, 16'h5A3C);
        exp_crc = 16'h5A3C;
        settle(3);
        check(32'(user_gp_result), 32'(exp_crc));
        // back to back, one byte per clock, 8'h00 and 8'hFF included
        @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            user_gp_wr <= 1'b1;
            user_gp_byte <= 8'(i * 17);
            exp_crc = ref_byte(exp_crc, 8'(i * 17));
            @(posedge clk);
        end
        user_gp_wr <= 1'b0;
        settle(3);
        check(32'(user_gp_result), 32'(exp_crc));
        user_req(2, 16'hFFFF);
        settle(3);
        check(32'(user_fast_result), 32'h0000_FFFF);
        user_req(2, 16'h0000);
        user_req(3, 16'h0080);
        settle(2);
        check(32'(ctl_enable), 32'h0000_0001);
        exp_crc = 16'h0000;
        for (int a = 0; a < 16380; a += 4) exp_crc = ref_word(exp_crc, flash_word(19'(a)));
        user_req(4, 16'h0000);
        wait_done(6000);
        settle(1);
        check(32'(user_fast_result), 32'(exp_crc));
        check(32'(user_fast_result[7:0]), 32'(exp_crc[7:0]));
        check(32'(user_halted), 32'h0000_0000);
        check(32'(ctl_end_block), 32'h0000_0000);
        check(32'(n_rd), 32'h0000_0FFF);
        // one word a clock, plus one cycle of flash answer and one through the buffer
        check(32'(n_busy), 32'h0000_1001);
        settle(20);
        check(32'(user_fast_result), 32'(exp_crc));
        // end field 6'h20 is prohibited: no sweep, core woken at once
        user_req(3, 16'h00A0);
        settle(2);
        user_req(4, 16'h0000);
        wait_done(20);
        settle(1);
        check(32'(range_err), 32'h0000_0001);
        check(32'(user_fast_result), 32'(exp_crc));
        check(32'(user_halted), 32'h0000_0000);
        check(32'(n_rd), 32'h0000_0000);
        // byte engine standing in for the fast one: high address byte first, each bit-reversed
        user_req(1, 16'h0000);
        exp_crc = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            w = flash_word(19'(4 * i));
            exp_crc = ref_word(exp_crc, w);
            for (int j = 3; j >= 0; j--) begin
                b = {<<{w[8 * j +: 8]}};
                user_req(0, {8'h00, b});
            end
        end
        settle(3);
        got = {<<{user_gp_result}};
        check(32'(got), 32'(exp_crc));
        // second sweep from a nonzero seed, words pass the buffer inside the crc end
        user_req(2, 16'h1D0F);
        user_req(3, 16'h0080);
        settle(2);
        exp_crc = 16'h1D0F;
        for (int a = 0; a < 16380; a += 4) exp_crc = ref_word(exp_crc, flash_word(19'(a)));
        user_req(4, 16'h0000);
        wait_done(6000);
        settle(1);
        check(32'(user_fast_result), 32'(exp_crc));
        check(32'(n_rv), 32'h0000_0FFF);
        check(32'(ctl_enable), 32'h0000_0000);
        check(32'(range_err), 32'h0000_0000);
        stop_test();
    end
endmodule : dcrc_dual_crc16_checker_tb

// [dcrc_if.sv]
// link between the crc unit and the processor core with its code flash
interface dcrc_if;
    import dcrc_pkg::*;

    logic cpu_halted;
    logic ctl_wr;
    logic [7:0] ctl_data;
    logic fast_seed_wr;
    logic gp_seed_wr;
    logic [15:0] seed_data;
    logic gp_wr;
    logic [7:0] gp_byte;
    logic wake;
    logic sweep_busy;
    logic [15:0] fast_result;
    logic [15:0] gp_result;
    logic flash_rd;
    logic [DCRC_BADDR_W-1:0] flash_addr;
    logic flash_rvalid;
    logic [31:0] flash_rdata;

    modport crc_end (
        input cpu_halted, ctl_wr, ctl_data, fast_seed_wr, gp_seed_wr, seed_data, gp_wr, gp_byte,
        input flash_rvalid, flash_rdata,
        output wake, sweep_busy, fast_result, gp_result, flash_rd, flash_addr
    );

    modport cpu_end (
        output cpu_halted, ctl_wr, ctl_data, fast_seed_wr, gp_seed_wr, seed_data, gp_wr, gp_byte,
        output flash_rvalid, flash_rdata,
        input wake, sweep_busy, fast_result, gp_result, flash_rd, flash_addr
    );
endinterface : dcrc_if

// [dcrc_link_chk.sv]
// concurrent checks on the link between the crc end and the cpu end
module dcrc_link_chk
    import dcrc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cpu_halted,
    input wire logic ctl_wr,
    input wire logic [7:0] ctl_data,
    input wire logic fast_seed_wr,
    input wire logic gp_seed_wr,
    input wire logic [15:0] seed_data,
    input wire logic gp_wr,
    input wire logic wake,
    input wire logic sweep_busy,
    input wire logic [15:0] fast_result,
    input wire logic [15:0] gp_result,
    input wire logic flash_rd,
    input wire logic [DCRC_BADDR_W-1:0] flash_addr,
    input wire logic flash_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [5:0] blk_r;
    logic [20:0] last_addr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // mirror of the accepted end field; writes while halted or busy never reach it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            blk_r <= 6'h00;
        end else if (ctl_wr && !sweep_busy && !cpu_halted) begin
            blk_r <= ctl_data[5:0];
        end
    end

    // 21 bits so a prohibited field cannot wrap the bound
    assign last_addr = (21'(blk_r) + 21'h1) * 21'h4000 - 21'h8;

    rd_needs_halt_a: assert property (
        flash_rd |-> cpu_halted && sweep_busy) else $error("flash read outside a halted sweep");
    rd_in_range_a: assert property (
        flash_rd |-> {2'b00, flash_addr} <= last_addr) else $error("flash read beyond sweep end");
    rd_aligned_a: assert property (
        flash_rd |-> flash_addr[1:0] == 2'b00) else $error("flash read not word aligned");
    sweep_from_zero_a: assert property (
        $rose(sweep_busy) |-> flash_rd && flash_addr == 19'h0_0000) else $error("sweep not started at zero");
    rd_step_four_a: assert property (
        flash_rd ##1 flash_rd |-> flash_addr == $past(flash_addr) + 19'h4) else $error("flash reads not contiguous");
    rd_answered_a: assert property (
        flash_rd |=> flash_rvalid) else $error("flash word not returned next cycle");
    wake_ends_halt_a: assert property (
        wake |=> !wake && !cpu_halted) else $error("core not released after wake");
    fast_held_a: assert property (
        !sweep_busy && !fast_seed_wr |=> $stable(fast_result)) else $error("fast result moved while idle");
    fast_seed_load_a: assert property (
        fast_seed_wr && !sweep_busy && !cpu_halted |=> fast_result == $past(seed_data))
        else $error("fast seed not loaded");
    gp_held_a: assert property (
        !gp_wr && !gp_seed_wr |=> $stable(gp_result)) else $error("byte result moved without a write");
    gp_seed_load_a: assert property (
        gp_seed_wr && !gp_wr |=> gp_result == $past(seed_data)) else $error("byte seed not loaded");
endmodule : dcrc_link_chk

// [dcrc_pkg.sv]
// constants, types and crc step functions shared by both ends of the dual crc unit
package dcrc_pkg;

    // generator 0x11021 with the implied top bit dropped
    localparam logic [15:0] DCRC_POLY = 16'h1021;
    // same generator bit-reversed, for the lsb-first byte engine
    localparam logic [15:0] DCRC_POLY_REFL = 16'h8408;
    localparam logic [15:0] DCRC_ACC_RST = 16'h0000;

    // flash_crc_control layout: enable, one zero bit, six-bit end block field
    localparam int DCRC_CTL_EN_BIT = 7;
    localparam int DCRC_CTL_BLK_LSB = 0;
    localparam int DCRC_CTL_BLK_W = 6;
    localparam logic [7:0] DCRC_CTL_RST = 8'h00;
    // end block values above this are prohibited
    localparam logic [5:0] DCRC_BLK_MAX = 6'h1F;

    // one 16-kilobyte block holds 4096 words; address zero is always the start
    localparam int DCRC_BLK_SHIFT = 12;
    localparam int DCRC_WADDR_W = 17;
    localparam int DCRC_BADDR_W = 19;
    localparam logic [DCRC_WADDR_W-1:0] DCRC_SWEEP_START = 17'h0_0000;
    localparam logic [17:0] DCRC_CNT_RST = 18'h0_0000;

    // word buffer between flash and fast engine
    localparam int DCRC_FIFO_W = 32;
    localparam int DCRC_FIFO_DEPTH = 32;
    localparam int DCRC_FIFO_CNT_W = 6;
    localparam logic [31:0] DCRC_WORD_RST = 32'h0000_0000;

    typedef enum logic [1:0] {
        DCRC_S_IDLE = 2'b00,
        DCRC_S_SWEEP = 2'b01,
        DCRC_S_DONE = 2'b10
    } dcrc_state_t;

    // msb first, bit 31 down to bit 0, no reflection
    function automatic logic [15:0] dcrc_step_word(input logic [15:0] crc, input logic [31:0] word);
        logic [15:0] c;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            if (c[15] ^ word[i]) begin
                c = {c[14:0], 1'b0} ^ DCRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : dcrc_step_word

    // lsb first, bit 0 up to bit 7, register held in reflected form
    function automatic logic [15:0] dcrc_step_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            if (c[0]) begin
                c = {1'b0, c[15:1]} ^ DCRC_POLY_REFL;
            end else begin
                c = {1'b0, c[15:1]};
            end
        end
        return c;
    endfunction : dcrc_step_byte

endpackage : dcrc_pkg
